// *** hw/sac_pkg.sv ***
//
// Purpose: Shared constants for the SAR converter control block
// Assumes: APB register slave, one word per register
// Notes:   Counts are in conversion clock ticks unless stated
//
package sac_pkg;

  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_SC1  = 8'h00;  // Channel, irq enable, done flag
  localparam logic [7:0] OFS_CONFIG_ONE = 8'h04;  // Clock source, divider, resolution
  localparam logic [7:0] OFS_CFG2 = 8'h08;  // Long sample select, speed, clock out
  localparam logic [7:0] OFS_SC2  = 8'h0C;  // Trigger, compare, dma, active
  localparam logic [7:0] OFS_SC3  = 8'h10;  // Calibration, continuous, averaging
  localparam logic [7:0] OFS_CV1  = 8'h14;  // First compare value
  localparam logic [7:0] OFS_CV2  = 8'h18;  // Second compare value
  localparam logic [7:0] OFS_RES  = 8'h1C;  // Conversion result

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int SC1_IEN   = 6;   // done_irq_enable
  localparam int SC1_DONE  = 7;   // conv_done_flag, read only
  localparam int CONFIG_ONE_RES  = 2;   // Resolution select, 2 bits
  localparam int CONFIG_ONE_LSMP = 4;   // Long sample enable
  localparam int CONFIG_ONE_DIV  = 5;   // Divider select, 2 bits
  localparam int CFG2_HS   = 2;   // High speed, two extra ticks
  localparam int CFG2_ACKO = 3;   // Async clock output enable
  localparam int SC2_DMA   = 2;   // DMA enable
  localparam int SC2_RNG   = 3;   // Compare mode, 2 bits
  localparam int SC2_CMPE  = 5;   // Compare enable
  localparam int SC2_TRG   = 6;   // trigger_type_bit
  localparam int SC2_ACT   = 7;   // Conversion active, read only
  localparam int SC2_ASST  = 8;   // Trigger assist enable
  localparam int SC3_AVGS  = 0;   // Average count select, 2 bits
  localparam int SC3_AVGE  = 2;   // Averaging enable
  localparam int SC3_CONT  = 3;   // Continuous mode
  localparam int SC3_CAL_FAILED_FLAG  = 6;   // cal_failed_flag, write one to clear
  localparam int SC3_CAL   = 7;   // Calibration start / in progress

  // ****************************************************************
  // Reset values and codes
  // ****************************************************************
  localparam logic [4:0] CH_RST   = 5'h1F;  // Converter deactivated
  localparam logic [4:0] CH_OFF   = 5'h1F;  // Deactivate code
  localparam logic [9:0] REG_RST  = 10'h000;

  // ****************************************************************
  // Timing counts
  // ****************************************************************
  localparam logic [7:0] SMP_SHORT = 8'h04;  // Short sample time
  localparam logic [7:0] SMP_L24   = 8'h18;  // Long sample, 24 ticks
  localparam logic [7:0] SMP_L16   = 8'h10;  // Long sample, 16 ticks
  localparam logic [7:0] SMP_L10   = 8'h0A;  // Long sample, 10 ticks
  localparam logic [7:0] SMP_L6    = 8'h06;  // Long sample, 6 ticks
  localparam logic [7:0] CONV_OVH  = 8'h04;  // Fixed ticks around the bit steps
  localparam logic [7:0] HS_EXTRA  = 8'h02;  // High speed lengthening
  localparam logic [7:0] CAL_TICKS = 8'h40;  // Calibration run length

  // Sequencer states
  typedef enum logic [1:0] {
    SAC_IDLE,
    SAC_SAMPLE,
    SAC_CONV,
    SAC_CAL
  } sac_state_e;

endpackage

// *** hw/sac_top.sv ***
//
// Purpose: Conversion control for a SAR converter, APB register slave
// Assumes: Analog core returns a 16-bit left-aligned code on core_data
// Notes:   APB answers with one wait state, in the second access cycle
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps

module sac_top #(
  parameter int ASYNC_DIV = 3  // Bus cycles per async clock tick
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rstn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Trigger and system inputs
  input  wire logic        hw_trigger_in,
  input  wire logic        trigger_select_in,
  input  wire logic        alt_clk_tick,
  input  wire logic        stop_mode,
  // Analog core
  input  wire logic [15:0] core_data,
  output logic [4:0]       core_chan,
  output logic             core_sample,
  // Requests and clock out
  output logic             done_irq,
  output logic             dma_req,
  output logic             async_clock
);

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [4:0]  chan_q;        // Selected input
  logic        ien_q;         // done_irq_enable
  logic        done_q;        // conv_done_flag
  logic [6:0]  config_one_q;        // Source, resolution, long sample, divider
  logic [3:0]  cfg2_q;        // Long select, high speed, clock out
  logic [8:0]  sc2_q;         // Control part of SC2
  logic [3:0]  sc3_q;         // Averaging and continuous
  logic        cal_failed_flag_q;        // cal_failed_flag
  logic [15:0] cv1_q;         // compare_value_one
  logic [15:0] cv2_q;         // compare_value_two
  logic [15:0] res_q;         // result_register
  sac_pkg::sac_state_e st_q;  // Sequencer state
  logic        conv_act;      // Conversion or averaging in progress

  // APB decode; access completes on the edge where pready is high
  logic acc, wr, rd, hit;
  assign acc = psel & penable & pready;
  assign wr  = acc & pwrite;
  assign rd  = acc & ~pwrite;
  assign hit = (paddr[7:5] == 3'h0) & (paddr[1:0] == 2'h0);

  // Per-register write strobes and the result read strobe
  logic w_sc1, w_config_one, w_cfg2, w_sc2, w_sc3, w_cv1, w_cv2, r_res;
  assign w_sc1  = wr & (paddr == sac_pkg::OFS_SC1);
  assign w_config_one = wr & (paddr == sac_pkg::OFS_CONFIG_ONE);
  assign w_cfg2 = wr & (paddr == sac_pkg::OFS_CFG2);
  assign w_sc2  = wr & (paddr == sac_pkg::OFS_SC2);
  assign w_sc3  = wr & (paddr == sac_pkg::OFS_SC3);
  assign w_cv1  = wr & (paddr == sac_pkg::OFS_CV1);
  assign w_cv2  = wr & (paddr == sac_pkg::OFS_CV2);
  assign r_res  = rd & (paddr == sac_pkg::OFS_RES);

  // ****************************************************************
  // APB answer
  // ****************************************************************
  // One wait state so read data comes from a flop
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h00000000;
    end else begin
      pready  <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      prdata  <= 32'h00000000;
      if (psel & penable & ~pready & ~pwrite & hit) begin
        unique case (paddr)
          sac_pkg::OFS_SC1:  prdata[7:0] <= {done_q, ien_q, 1'b0, chan_q};
          sac_pkg::OFS_CONFIG_ONE: prdata[6:0] <= config_one_q;
          sac_pkg::OFS_CFG2: prdata[3:0] <= cfg2_q;
          sac_pkg::OFS_SC2:  prdata[8:0] <= {sc2_q[8], conv_act, sc2_q[6:0]};
          sac_pkg::OFS_SC3:  prdata[7:0] <= {st_q == sac_pkg::SAC_CAL, cal_failed_flag_q, 2'b00, sc3_q};
          sac_pkg::OFS_CV1:  prdata[15:0] <= cv1_q;
          sac_pkg::OFS_CV2:  prdata[15:0] <= cv2_q;
          default:           prdata[15:0] <= res_q;
        endcase
      end
    end
  end

  // ****************************************************************
  // Conversion clock
  // ****************************************************************
  logic       half_q;   // Bus clock divided by two
  logic [7:0] acnt_q;   // Async oscillator divider
  logic       atick;    // Async clock tick
  logic       src_tick; // Selected input clock tick
  logic [2:0] div_q;    // Conversion clock divider
  logic       ctick;    // conversion_clock tick
  logic [2:0] div_max;  // Divider top count
  logic       busy;     // Sequencer not idle

  assign busy  = (st_q != sac_pkg::SAC_IDLE);
  assign atick = (acnt_q == 8'(ASYNC_DIV - 1));

  // Async source runs when used or when its output is enabled
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      acnt_q      <= 8'h00;
      async_clock <= 1'b0;
    end else if (cfg2_q[sac_pkg::CFG2_ACKO] || (busy && config_one_q[1:0] == 2'h3)) begin
      acnt_q <= atick ? 8'h00 : acnt_q + 8'h01;
      if (atick && cfg2_q[sac_pkg::CFG2_ACKO]) begin
        async_clock <= ~async_clock;
      end
    end else begin
      acnt_q <= 8'h00;
    end
  end

  // Input source: bus, bus/2, alternate, async
  always_comb begin
    unique case (config_one_q[1:0])
      2'h0:    src_tick = 1'b1;
      2'h1:    src_tick = half_q;
      2'h2:    src_tick = alt_clk_tick;
      default: src_tick = atick;
    endcase
  end

  // Divide ratio 1, 2, 4 or 8
  always_comb begin
    unique case (config_one_q[sac_pkg::CONFIG_ONE_DIV +: 2])
      2'h0:    div_max = 3'h0;
      2'h1:    div_max = 3'h1;
      2'h2:    div_max = 3'h3;
      default: div_max = 3'h7;
    endcase
  end
  assign ctick = src_tick & (div_q == div_max);

  // Divider restarts when idle so each run starts aligned
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      half_q <= 1'b0;
      div_q  <= 3'h0;
    end else begin
      half_q <= ~half_q;
      if (!busy || ctick) begin
        div_q <= 3'h0;
      end else if (src_tick) begin
        div_q <= div_q + 3'h1;
      end
    end
  end

  // ****************************************************************
  // Phase lengths
  // ****************************************************************
  logic [7:0] smp_len, conv_len, res_bits;
  always_comb begin
    unique case (cfg2_q[1:0])
      2'h0:    smp_len = sac_pkg::SMP_L24;
      2'h1:    smp_len = sac_pkg::SMP_L16;
      2'h2:    smp_len = sac_pkg::SMP_L10;
      default: smp_len = sac_pkg::SMP_L6;
    endcase
    if (!config_one_q[sac_pkg::CONFIG_ONE_LSMP]) begin
      smp_len = sac_pkg::SMP_SHORT;
    end
    unique case (config_one_q[sac_pkg::CONFIG_ONE_RES +: 2])
      2'h0:    res_bits = 8'd8;
      2'h1:    res_bits = 8'd12;
      2'h2:    res_bits = 8'd10;
      default: res_bits = 8'd16;
    endcase
    conv_len = res_bits + sac_pkg::CONV_OVH
             + (cfg2_q[sac_pkg::CFG2_HS] ? sac_pkg::HS_EXTRA : 8'h00);
  end

  // ****************************************************************
  // Sample shaping, averaging and compare
  // ****************************************************************
  logic [15:0] samp;      // Right-justified unsigned sample
  logic [20:0] acc_q;     // Averaging sum
  logic [4:0]  avn_q;     // Samples taken in this run
  logic [4:0]  av_last;   // Last sample index of a run
  logic [20:0] sum;       // Sum including this sample
  logic [15:0] mean;      // Average of the run
  logic        last;      // This sample ends the run
  logic        cmp_ok;    // Compare passes or disabled
  logic [15:0] fin;       // Value to store

  // Truncate to resolution, low bits hold the result
  assign samp = core_data >> (5'd16 - res_bits[4:0]);

  // Count 4, 8, 16 or 32 samples
  assign av_last = 5'((6'd4 << sc3_q[1:0]) - 6'd1);
  assign last    = ~sc3_q[sac_pkg::SC3_AVGE] | (avn_q == av_last);
  assign sum     = acc_q + {5'h00, samp};
  assign mean    = 16'(sum >> (3'd2 + {1'b0, sc3_q[1:0]}));
  assign fin     = sc3_q[sac_pkg::SC3_AVGE] ? mean : samp;

  // Compare against CV1, CV2 only in range modes, same format as result
  always_comb begin
    unique case (sc2_q[sac_pkg::SC2_RNG +: 2])
      2'h0: cmp_ok = fin < cv1_q;
      2'h1: cmp_ok = fin >= cv1_q;
      2'h2: cmp_ok = (cv1_q <= cv2_q) ? (fin > cv1_q && fin < cv2_q)
                                      : (fin < cv2_q || fin > cv1_q);
      default: cmp_ok = (cv1_q <= cv2_q) ? (fin >= cv1_q && fin <= cv2_q)
                                         : (fin <= cv2_q || fin >= cv1_q);
    endcase
    if (!sc2_q[sac_pkg::SC2_CMPE]) begin
      cmp_ok = 1'b1;
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  logic [7:0] cnt_q;     // Ticks left in the phase
  logic       armed_q;   // Trigger select pulse seen
  logic       hwt_q;     // Previous trigger level
  logic       start;     // Begin a conversion
  logic       conv_end;  // Conversion phase ends on this tick
  logic       done_ev;   // Completed result accepted
  logic       cal_abort; // Calibration disturbed
  logic       any_wr;    // Any register written

  assign any_wr   = wr & hit;
  assign conv_act = (st_q == sac_pkg::SAC_SAMPLE) | (st_q == sac_pkg::SAC_CONV);
  assign conv_end = (st_q == sac_pkg::SAC_CONV) & ctick & (cnt_q == 8'h01);
  assign done_ev  = conv_end & last & cmp_ok;

  // Software write checks the channel being written, as the stored one is
  // still the old value in that cycle; a hardware edge checks the stored one
  assign start = (st_q != sac_pkg::SAC_CAL) & (
      sc2_q[sac_pkg::SC2_TRG] ? (armed_q & hw_trigger_in & ~hwt_q & (chan_q != sac_pkg::CH_OFF))
                              : (w_sc1 && pwdata[4:0] != sac_pkg::CH_OFF));
  assign cal_abort = (st_q == sac_pkg::SAC_CAL)
                   & (sc2_q[sac_pkg::SC2_TRG] | any_wr | stop_mode);

  // Hardware trigger arming
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      armed_q <= 1'b0;
      hwt_q   <= 1'b0;
    end else begin
      hwt_q <= hw_trigger_in;
      if (trigger_select_in) begin
        armed_q <= 1'b1;
      end else if (start && sc2_q[sac_pkg::SC2_TRG]) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Phase state and counting
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      st_q  <= sac_pkg::SAC_IDLE;
      cnt_q <= 8'h00;
      acc_q <= 21'h000000;
      avn_q <= 5'h00;
    end else if (cal_abort) begin
      st_q <= sac_pkg::SAC_IDLE;
    end else if (w_sc3 && pwdata[sac_pkg::SC3_CAL] && !sc2_q[sac_pkg::SC2_TRG]) begin
      st_q  <= sac_pkg::SAC_CAL;
      cnt_q <= sac_pkg::CAL_TICKS;
    end else if (start || (w_sc1 && busy)) begin
      st_q  <= start ? sac_pkg::SAC_SAMPLE : sac_pkg::SAC_IDLE;
      cnt_q <= smp_len;
      acc_q <= 21'h000000;
      avn_q <= 5'h00;
    end else if (ctick) begin
      unique case (st_q)
        sac_pkg::SAC_SAMPLE: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q  <= sac_pkg::SAC_CONV;
            cnt_q <= conv_len;
          end
        end
        sac_pkg::SAC_CONV: begin
          cnt_q <= cnt_q - 8'h01;
          if (conv_end) begin
            acc_q <= last ? 21'h000000 : sum;
            avn_q <= last ? 5'h00 : avn_q + 5'h01;
            cnt_q <= smp_len;
            // Continuous mode keeps going, single returns idle after the last sample of the run
            st_q  <= (last && !sc3_q[sac_pkg::SC3_CONT])
                   ? sac_pkg::SAC_IDLE : sac_pkg::SAC_SAMPLE;
          end
        end
        sac_pkg::SAC_CAL: begin
          cnt_q <= cnt_q - 8'h01;
          if (cnt_q == 8'h01) begin
            st_q <= sac_pkg::SAC_IDLE;
          end
        end
        default: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // ****************************************************************
  // Software registers
  // ****************************************************************
  // Control fields; trigger assist mirrors the done bit write
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      chan_q <= sac_pkg::CH_RST;
      ien_q  <= 1'b0;
      config_one_q <= sac_pkg::REG_RST[6:0];
      cfg2_q <= sac_pkg::REG_RST[3:0];
      sc2_q  <= sac_pkg::REG_RST[8:0];
      sc3_q  <= sac_pkg::REG_RST[3:0];
      cv1_q  <= 16'h0000;
      cv2_q  <= 16'h0000;
    end else begin
      if (w_sc1) begin
        chan_q <= pwdata[4:0];
        ien_q  <= pwdata[sac_pkg::SC1_IEN];
        if (sc2_q[sac_pkg::SC2_ASST]) begin
          sc2_q[sac_pkg::SC2_TRG] <= pwdata[sac_pkg::SC1_DONE];
        end
      end
      if (w_config_one) config_one_q <= pwdata[6:0];
      if (w_cfg2) cfg2_q <= pwdata[3:0];
      if (w_sc2)  sc2_q  <= {pwdata[8], 1'b0, pwdata[6:0]};
      if (w_sc3)  sc3_q  <= pwdata[3:0];
      if (w_cv1)  cv1_q  <= pwdata[15:0];
      if (w_cv2)  cv2_q  <= pwdata[15:0];
    end
  end

  // Done flag: a completion in the clearing cycle still sets it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      done_q <= 1'b0;
      res_q  <= 16'h0000;
    end else begin
      if (done_ev) begin
        done_q <= 1'b1;
        res_q  <= fin;
      end else if (w_sc1 || r_res) begin
        done_q <= 1'b0;
      end
    end
  end

  // Calibration failed, write one clears, abort wins
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cal_failed_flag_q <= 1'b0;
    end else if (cal_abort) begin
      cal_failed_flag_q <= 1'b1;
    end else if (w_sc3 && pwdata[sac_pkg::SC3_CAL_FAILED_FLAG]) begin
      cal_failed_flag_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs to core and system
  // ****************************************************************
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      done_irq    <= 1'b0;
      dma_req     <= 1'b0;
      core_chan   <= sac_pkg::CH_RST;
      core_sample <= 1'b0;
    end else begin
      done_irq    <= done_q & ien_q;
      dma_req     <= done_ev & sc2_q[sac_pkg::SC2_DMA];
      core_chan   <= chan_q;
      core_sample <= (st_q == sac_pkg::SAC_SAMPLE);
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  chk_done_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (w_sc1 || r_res) && !done_ev |=> !done_q) else $error("done not cleared");
  chk_irq_follow: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_q) && ien_q && !w_sc1 |=> done_irq) else $error("irq missing");
  chk_dma_pulse: assert property (@(posedge mclk) disable iff (!rstn)
    done_ev && sc2_q[sac_pkg::SC2_DMA] |=> dma_req ##1 !dma_req || done_q)
    else $error("dma request wrong");
  chk_cal_abort: assert property (@(posedge mclk) disable iff (!rstn)
    st_q == sac_pkg::SAC_CAL && stop_mode |=> cal_failed_flag_q && !busy)
    else $error("calibration not aborted");
  chk_cal_failed_flag_clear: assert property (@(posedge mclk) disable iff (!rstn)
    w_sc3 && pwdata[sac_pkg::SC3_CAL_FAILED_FLAG] && !cal_abort |=> !cal_failed_flag_q)
    else $error("failed flag not cleared");
  chk_single_end: assert property (@(posedge mclk) disable iff (!rstn)
    conv_end && last && !sc3_q[sac_pkg::SC3_CONT] && !start && !w_sc1 && !w_sc3
    |=> !conv_act ##1 (!conv_act || $past(start))) else $error("single mode kept running");
  chk_sw_start: assert property (@(posedge mclk) disable iff (!rstn)
    start && !w_sc3 && !cal_abort |=> st_q == sac_pkg::SAC_SAMPLE && conv_act)
    else $error("start not taken");
  chk_cmp_gate: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(done_q) |-> $past(cmp_ok) && $past(conv_end))
    else $error("done without passing compare");

endmodule // sac_top

// *** bench/test_sar_adc_conversion_control.sv ***
//
// Purpose: Self-checking bench for the SAR converter control block
// Assumes: APB answers with one wait state, analog core held by the bench
// Notes:   Alternate clock stays idle; triggers and stop mode are driven
//
`timescale 1ns/1ps

module test_sar_adc_conversion_control;

  // ****************************************************************
  // Signals
  // ****************************************************************
  logic        mclk, rstn, psel, penable, pwrite;  // Clock, reset, APB controls
  logic [7:0]  paddr;                               // APB byte address
  logic [31:0] pwdata, prdata, rd;                  // Write data, read data, last read
  logic        pready, pslverr, er, hit;            // Answer, error, last error, done seen
  logic [15:0] core_data, cd;                       // Held analog code
  logic [4:0]  core_chan, ch;                       // Selected channel
  logic        core_sample, done_irq, dma_req, async_clock;
  logic [1:0]  k;                                   // Field value of the loop pass
  logic        hw_trigger_in, trigger_select_in, stop_mode, ac;  // Driven inputs, clock sample
  int          fails, num_checks, seed, dma_n;      // Counters and seed
  int          exp_q[$];                            // Model: expected results in order
  int          shift_t[4] = '{8, 4, 6, 0};          // Right shift per resolution code

  sac_top DUT (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .hw_trigger_in(hw_trigger_in), .trigger_select_in(trigger_select_in),
    .alt_clk_tick(1'b0), .stop_mode(stop_mode), .core_data(core_data),
    .core_chan(core_chan), .core_sample(core_sample), .done_irq(done_irq),
    .dma_req(dma_req), .async_clock(async_clock));

  // ****************************************************************
  // Clock, DMA counter and watchdog
  // ****************************************************************
  initial mclk = 1'b0;
  always #50 mclk = ~mclk;
  // Each one-cycle request pulse counts once
  always @(posedge mclk) if (dma_req === 1'b1) dma_n++;
  // Longest legal run is far below this span
  initial begin
    #(60000 * 100);
    fails++;
    complete_run();
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    if (g !== e) begin
      $display("BAD %0t got %h expected %h", $time, g, e);
      fails++;
    end
    num_checks++;
  endtask

  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 20) chk(1'b0, 1'b1);
    @(posedge mclk);
  endtask

  // Bounded wait for the interrupt line
  task automatic wt(input int lim);
    int n;
    n = 0;
    while (done_irq !== 1'b1 && n < lim) begin
      @(posedge mclk);
      n++;
    end
    hit = (done_irq === 1'b1);
  endtask

  task automatic complete_run();
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 96; fails = 0; num_checks = 0; dma_n = 0;
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; core_data = 16'h0;
    hw_trigger_in = 1'b0; trigger_select_in = 1'b0; stop_mode = 1'b0;
    repeat (20) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    apb(1'b0, sac_pkg::OFS_SC1, 32'h0); chk(rd, 32'h0000001F);
    apb(1'b0, 8'h20, 32'h0); chk(er, 1'b1);
    chk(rd, 32'h0);
    // Every resolution and divider, long samples of 16 and 6 ticks, averaging counts of 8 and 32
    for (int i = 0; i < 4; i++) begin
      k = i[1:0];
      cd = $random(seed);
      ch = 5'({$random(seed)} % 24);
      core_data <= cd;
      apb(1'b1, sac_pkg::OFS_CONFIG_ONE, {25'h0, k, k[0], k, k == 2'h3, k[1]});
      apb(1'b1, sac_pkg::OFS_CFG2, {28'h0, k[1], k[1], k});
      apb(1'b1, sac_pkg::OFS_SC3, {29'h0, k[0], k});
      apb(1'b1, sac_pkg::OFS_SC2, 32'h00000004);
      apb(1'b1, sac_pkg::OFS_SC1, {25'h0, 2'h2, ch});
      exp_q.push_back(int'(cd) >> shift_t[i]);
      wt(30000); chk(hit, 1'b1);
      ac = async_clock;
      repeat (3) @(posedge mclk);
      chk(async_clock, ac ^ k[1]);
      chk(core_chan, ch);
      apb(1'b0, sac_pkg::OFS_SC2, 32'h0); chk(rd, 32'h00000004);
      apb(1'b0, sac_pkg::OFS_RES, 32'h0); chk(rd, exp_q.pop_front());
      apb(1'b0, sac_pkg::OFS_SC1, 32'h0); chk(rd, {25'h0, 2'h2, ch});
      chk(done_irq, 1'b0);
    end
    chk(dma_n, 4);
    // Compare modes on a fixed 8-bit code of 0x80
    apb(1'b1, sac_pkg::OFS_CONFIG_ONE, 32'h0);
    apb(1'b1, sac_pkg::OFS_CFG2, 32'h0);
    apb(1'b1, sac_pkg::OFS_SC3, 32'h0);
    core_data <= 16'h8000;
    for (int m = 0; m < 4; m++) begin
      k = m[1:0];
      apb(1'b1, sac_pkg::OFS_CV1, (m == 0) ? 32'h81 : (m == 1) ? 32'h81 : (m == 2) ? 32'h10 : 32'h90);
      apb(1'b1, sac_pkg::OFS_CV2, (m < 2) ? 32'h00 : (m == 2) ? 32'h90 : 32'h10);
      apb(1'b1, sac_pkg::OFS_SC2, {26'h0, 1'b1, k, 3'h0});
      apb(1'b1, sac_pkg::OFS_SC1, 32'h00000045);
      wt(300); chk(hit, k == 2'h0 || k == 2'h2);
      apb(1'b0, sac_pkg::OFS_RES, 32'h0);
      if (hit) chk(rd, 32'h80);
    end
    // Assist copies the done bit into the trigger type, an armed edge starts
    apb(1'b1, sac_pkg::OFS_SC2, 32'h00000100);
    apb(1'b1, sac_pkg::OFS_SC3, 32'h00000008);
    apb(1'b1, sac_pkg::OFS_SC1, 32'h0000009F);
    apb(1'b0, sac_pkg::OFS_SC2, 32'h0); chk(rd, 32'h00000140);
    apb(1'b1, sac_pkg::OFS_SC1, 32'h000000C5);
    cd = $random(seed);
    core_data <= cd;
    trigger_select_in <= 1'b1;
    @(posedge mclk);
    trigger_select_in <= 1'b0;
    hw_trigger_in <= 1'b1;
    repeat (3) @(posedge mclk);
    chk(core_sample, 1'b1);
    wt(300); chk(hit, 1'b1);
    apb(1'b0, sac_pkg::OFS_SC2, 32'h0); chk(rd, 32'h000001C0);
    apb(1'b0, sac_pkg::OFS_RES, 32'h0); chk(rd, {24'h0, cd[15:8]});
    @(posedge mclk);
    chk(done_irq, 1'b0);
    wt(300); chk(hit, 1'b1);
    hw_trigger_in <= 1'b0;
    apb(1'b1, sac_pkg::OFS_SC1, 32'h0000001F);
    apb(1'b0, sac_pkg::OFS_SC2, 32'h0); chk(rd, 32'h00000100);
    // Calibration left alone finishes and drops its start bit
    apb(1'b1, sac_pkg::OFS_SC3, 32'h00000080);
    repeat (80) @(posedge mclk);
    apb(1'b0, sac_pkg::OFS_SC3, 32'h0); chk(rd, 32'h0);
    // Calibration runs, a foreign write aborts it, the flag clears on one
    apb(1'b1, sac_pkg::OFS_SC3, 32'h00000080);
    apb(1'b0, sac_pkg::OFS_SC3, 32'h0); chk(rd, 32'h00000080);
    apb(1'b1, sac_pkg::OFS_CV1, 32'h0);
    apb(1'b0, sac_pkg::OFS_SC3, 32'h0); chk(rd, 32'h00000040);
    apb(1'b1, sac_pkg::OFS_SC3, 32'h00000040);
    apb(1'b0, sac_pkg::OFS_SC3, 32'h0); chk(rd, 32'h0);
    // Stop mode entered during calibration aborts it as well
    apb(1'b1, sac_pkg::OFS_SC3, 32'h00000080);
    stop_mode <= 1'b1;
    @(posedge mclk);
    stop_mode <= 1'b0;
    apb(1'b0, sac_pkg::OFS_SC3, 32'h0); chk(rd, 32'h00000040);
    complete_run();
  end

endmodule // test_sar_adc_conversion_control
